// file: shared/swkc_defines.vh
// Constants for the stopwatch key control block
`ifndef SWKC_DEFINES_VH
`define SWKC_DEFINES_VH

// Timing
`define SWKC_PCLK_HZ 50000000
`define SWKC_TICK_HZ 1024
`define SWKC_TICK_DIV (`SWKC_PCLK_HZ / `SWKC_TICK_HZ)
`define SWKC_DEB_TIME_US 46800
`define SWKC_DEB_TICKS ((`SWKC_DEB_TIME_US * `SWKC_TICK_HZ + 999999) / 1000000)

// Register byte offsets
`define SWKC_OFS_CTRL 8'h00
`define SWKC_OFS_RUN 8'h04
`define SWKC_OFS_MILLIS 8'h08
`define SWKC_OFS_CENTIS 8'h0C
`define SWKC_OFS_DECIS 8'h10
`define SWKC_OFS_FLAGS 8'h14
`define SWKC_OFS_MASK 8'h18
`define SWKC_OFS_KEYS 8'h1C

// Control register fields
`define SWKC_CTRL_DIRECT 0
`define SWKC_CTRL_SWAP 1
`define SWKC_CTRL_COMBO_LO 2
`define SWKC_CTRL_COMBO_HI 4

// Flag register fields
`define SWKC_FLG_TEN_HZ 0
`define SWKC_FLG_ONE_HZ 1
`define SWKC_FLG_RUN_KEY 2
`define SWKC_FLG_LAP_KEY 3
`define SWKC_FLG_RENEWED 4
`define SWKC_FLG_CARRY 5

// Reset values
`define SWKC_CTRL_RESET 5'h00
`define SWKC_MASK_RESET 4'h0
`define SWKC_FLAGS_RESET 4'h0

`endif

// file: design/swkc_key_filter.v
// Press detection and release debounce for one stopwatch key
`timescale 1ns/10ps
`include "swkc_defines.vh"

module swkc_key_filter
#(
   parameter DEB_TICKS = `SWKC_DEB_TICKS,
   parameter CW = 7
)
(
   input wire pclk,
   input wire presetn,
   input wire tick,
   input wire key_lvl,
   input wire allow,
   input wire enable,
   output reg active_reg,
   output reg press_reg
);

   localparam [31:0] LAST_W = DEB_TICKS - 1;
   localparam [CW-1:0] LAST = LAST_W[CW-1:0];

   reg prev_reg;
   reg [CW-1:0] cnt_reg;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_reg <= 1'b0;
         active_reg <= 1'b0;
         press_reg <= 1'b0;
         cnt_reg <= {CW{1'b0}};
      end
      else
      begin
         press_reg <= 1'b0;
         if (tick)
         begin
            prev_reg <= key_lvl;
            if (active_reg)
            begin
               // Judged at release: the key must stay off for the whole window
               if (key_lvl)
                  cnt_reg <= {CW{1'b0}};
               else if (cnt_reg == LAST)
                  active_reg <= 1'b0;
               else
                  cnt_reg <= cnt_reg + 1'b1;
            end
            else if (enable && key_lvl && !prev_reg && allow)
            begin
               // Rising edge of the internal key signal
               active_reg <= 1'b1;
               press_reg <= 1'b1;
               cnt_reg <= {CW{1'b0}};
            end
         end
      end
   end

endmodule

// file: design/swkc_top.v
// Stopwatch direct key control with capture buffer, flags and APB registers
//
// Behaviour
// - Direct key enable gives keys run/lap control
// - Swap bit exchanges run and lap keys
// - Accepted run press toggles run state
// - Run state bit reads current running state
// - Key lines stay readable as port bits
// - Keys sampled on each 1024 Hz tick
// - Release debounce rejects bounce under 46.8 ms
// - Lap press captures digits, counting continues
// - Lap during hold renews; decis read flags
// - Decis overflow sets one hertz flag
// - Entering hold reloads carry request from flag
// - Combo select picks mask key set
// - Press during held mask is ignored
// - Lone, joint or with-mask presses accepted
// - Same-tick samples count as simultaneous
// - Digit overflows set ten and one hertz flags
// - Overflow masks gate only the requests
// - Key flags set on internal key rising edge
// - Key masks gate only the requests
// - Millis read latches digits; decis read releases unless a renewal is pending
// - Run bit read-only under direct control
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "swkc_defines.vh"

module swkc_top
#(
   parameter TICK_DIV = `SWKC_TICK_DIV,
   parameter DIV_W = 16,
   parameter DEB_TICKS = `SWKC_DEB_TICKS
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [7:0] key_pins,
   input wire [3:0] millis_digit,
   input wire [3:0] centis_digit,
   input wire [3:0] decis_digit,
   input wire centis_overflow,
   input wire decis_overflow,
   output reg tick_1024_reg,
   output reg run_state_reg,
   output reg [7:0] key_level_reg,
   output reg ten_hz_irq_reg,
   output reg one_hz_irq_reg,
   output reg run_key_irq_reg,
   output reg lap_key_irq_reg
);

   localparam [31:0] DIV_LAST_W = TICK_DIV - 1;
   localparam [DIV_W-1:0] DIV_LAST = DIV_LAST_W[DIV_W-1:0];

   // Register state
   reg [4:0] ctrl_reg;
   reg [3:0] mask_reg;
   reg [3:0] flags_reg;
   reg [3:0] flags_next;
   reg [11:0] cap_reg;
   reg hold_reg;
   reg renew_pend_reg;
   reg capture_renewed_flag_reg;
   reg lap_carry_request_reg;
   reg sw_run_req_reg;
   reg sw_run_val_reg;
   reg [DIV_W-1:0] div_reg;
   reg [7:0] key_meta_reg;
   reg [7:0] key_sync_reg;
   reg [7:0] key_smp_reg;
   reg [7:0] combo_keys;
   reg [31:0] rd_data;
   reg rd_err;

   wire direct_key_enable = ctrl_reg[`SWKC_CTRL_DIRECT];
   wire key_assign_swap = ctrl_reg[`SWKC_CTRL_SWAP];
   wire [2:0] combo_select = ctrl_reg[`SWKC_CTRL_COMBO_HI:`SWKC_CTRL_COMBO_LO];
   wire tick = (div_reg == DIV_LAST);
   wire [11:0] live_digits = {decis_digit, centis_digit, millis_digit};

   // APB: one wait state, the transfer completes where pready is seen high
   wire apb_req = psel && penable && !pready;
   wire apb_done = psel && penable && pready;
   wire wr_done = apb_done && pwrite;
   wire rd_done = apb_done && !pwrite;
   wire addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `SWKC_OFS_KEYS);

   wire rd_millis = rd_done && (paddr == `SWKC_OFS_MILLIS);
   wire rd_decis = rd_done && (paddr == `SWKC_OFS_DECIS);

   // Clock divider gives the falling-edge tick of the 1024 Hz timebase
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_reg <= {DIV_W{1'b0}};
         tick_1024_reg <= 1'b0;
      end
      else
      begin
         div_reg <= tick ? {DIV_W{1'b0}} : div_reg + 1'b1;
         tick_1024_reg <= tick;
      end
   end

   // Pins pass two flops before anything reads them
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         key_meta_reg <= 8'h00;
         key_sync_reg <= 8'h00;
         key_smp_reg <= 8'h00;
         key_level_reg <= 8'h00;
      end
      else
      begin
         key_meta_reg <= key_pins;
         key_sync_reg <= key_meta_reg;
         key_level_reg <= key_sync_reg;
         if (tick)
            key_smp_reg <= key_sync_reg;
      end
   end

   // Mask key set, bit order p0_0..p0_3 then p1_0..p1_3
   always @*
   begin
      case (combo_select)
         3'h1: combo_keys = 8'h04;
         3'h2: combo_keys = 8'h0C;
         3'h3: combo_keys = 8'h1C;
         3'h4: combo_keys = 8'h10;
         3'h5: combo_keys = 8'h30;
         3'h6: combo_keys = 8'h70;
         3'h7: combo_keys = 8'hF0;
         default: combo_keys = 8'h00;
      endcase
   end

   // A mask key held on the previous tick blocks the press; one arriving on the
   // same tick as the run or lap key counts as simultaneous and is allowed
   wire mask_held = |(key_smp_reg & combo_keys);
   wire key_allow = !mask_held;
   wire run_lvl = key_assign_swap ? key_sync_reg[1] : key_sync_reg[0];
   wire lap_lvl = key_assign_swap ? key_sync_reg[0] : key_sync_reg[1];

   wire run_active;
   wire run_press;
   wire lap_active;
   wire lap_press;

   swkc_key_filter #(.DEB_TICKS(DEB_TICKS), .CW(7)) u_run_key
   (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .key_lvl(run_lvl),
      .allow(key_allow),
      .enable(direct_key_enable),
      .active_reg(run_active),
      .press_reg(run_press)
   );

   swkc_key_filter #(.DEB_TICKS(DEB_TICKS), .CW(7)) u_lap_key
   (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .key_lvl(lap_lvl),
      .allow(key_allow),
      .enable(direct_key_enable),
      .active_reg(lap_active),
      .press_reg(lap_press)
   );

   // Run state: keys toggle it, software writes land on the next tick
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_state_reg <= 1'b0;
         sw_run_req_reg <= 1'b0;
         sw_run_val_reg <= 1'b0;
      end
      else
      begin
         if (direct_key_enable)
         begin
            sw_run_req_reg <= 1'b0;
            if (run_press)
               run_state_reg <= !run_state_reg;
         end
         else
         begin
            if (wr_done && paddr == `SWKC_OFS_RUN)
            begin
               sw_run_req_reg <= 1'b1;
               sw_run_val_reg <= pwdata[0];
            end
            else if (tick)
               sw_run_req_reg <= 1'b0;
            if (tick && sw_run_req_reg)
               run_state_reg <= sw_run_val_reg;
         end
      end
   end

   // Capture buffer and hold
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cap_reg <= 12'h000;
         hold_reg <= 1'b0;
         renew_pend_reg <= 1'b0;
         capture_renewed_flag_reg <= 1'b0;
         lap_carry_request_reg <= 1'b0;
      end
      else
      begin
         if (lap_press)
         begin
            cap_reg <= live_digits;
            hold_reg <= 1'b1;
            lap_carry_request_reg <= flags_reg[`SWKC_FLG_ONE_HZ];
            if (hold_reg)
               renew_pend_reg <= 1'b1;
         end
         else if (rd_millis && !hold_reg)
         begin
            cap_reg <= live_digits;
            hold_reg <= 1'b1;
            lap_carry_request_reg <= flags_reg[`SWKC_FLG_ONE_HZ];
         end
         else if (rd_decis)
         begin
            // A renewal keeps the hold so the fresh lap data is not lost
            capture_renewed_flag_reg <= renew_pend_reg;
            renew_pend_reg <= 1'b0;
            if (!renew_pend_reg)
               hold_reg <= 1'b0;
         end
      end
   end

   // Sticky flags: a set in the clearing cycle wins
   always @*
   begin
      flags_next = flags_reg;
      if (wr_done && paddr == `SWKC_OFS_FLAGS)
         flags_next = flags_reg & ~pwdata[3:0];
      if (centis_overflow)
         flags_next[`SWKC_FLG_TEN_HZ] = 1'b1;
      if (decis_overflow)
         flags_next[`SWKC_FLG_ONE_HZ] = 1'b1;
      if (run_press)
         flags_next[`SWKC_FLG_RUN_KEY] = 1'b1;
      if (lap_press)
         flags_next[`SWKC_FLG_LAP_KEY] = 1'b1;
   end

   // Control, masks, flags and interrupt requests
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= `SWKC_CTRL_RESET;
         mask_reg <= `SWKC_MASK_RESET;
         flags_reg <= `SWKC_FLAGS_RESET;
         ten_hz_irq_reg <= 1'b0;
         one_hz_irq_reg <= 1'b0;
         run_key_irq_reg <= 1'b0;
         lap_key_irq_reg <= 1'b0;
      end
      else
      begin
         if (wr_done && paddr == `SWKC_OFS_CTRL)
            ctrl_reg <= pwdata[4:0];
         if (wr_done && paddr == `SWKC_OFS_MASK)
            mask_reg <= pwdata[3:0];
         flags_reg <= flags_next;
         ten_hz_irq_reg <= flags_reg[0] & mask_reg[0];
         one_hz_irq_reg <= flags_reg[1] & mask_reg[1];
         run_key_irq_reg <= flags_reg[2] & mask_reg[2];
         lap_key_irq_reg <= flags_reg[3] & mask_reg[3];
      end
   end

   // Read mux; held digits come from the buffer, otherwise live
   always @*
   begin
      rd_data = 32'h00000000;
      rd_err = !addr_ok;
      case (paddr)
         `SWKC_OFS_CTRL: rd_data[4:0] = ctrl_reg;
         `SWKC_OFS_RUN: rd_data[0] = run_state_reg;
         `SWKC_OFS_MILLIS: rd_data[3:0] = hold_reg ? cap_reg[3:0] : millis_digit;
         `SWKC_OFS_CENTIS: rd_data[3:0] = hold_reg ? cap_reg[7:4] : centis_digit;
         `SWKC_OFS_DECIS: rd_data[3:0] = hold_reg ? cap_reg[11:8] : decis_digit;
         `SWKC_OFS_FLAGS:
         begin
            rd_data[3:0] = flags_reg;
            rd_data[`SWKC_FLG_RENEWED] = capture_renewed_flag_reg;
            rd_data[`SWKC_FLG_CARRY] = lap_carry_request_reg;
         end
         `SWKC_OFS_MASK: rd_data[3:0] = mask_reg;
         `SWKC_OFS_KEYS: rd_data[7:0] = key_level_reg;
         default: rd_data = 32'h00000000;
      endcase
   end

   // APB answer registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= apb_req;
         if (apb_req)
         begin
            pslverr <= rd_err;
            prdata <= pwrite ? 32'h00000000 : rd_data;
         end
         else
         begin
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
         end
      end
   end

endmodule

// file: test/swkc_properties.sv
// Checker for bus timing, tick pacing and key sampling of the stopwatch key block
`timescale 1ns/10ps
module swkc_props
#(
   parameter TICK_DIV = 8
)
(
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic [7:0] paddr,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic [7:0] key_pins,
   input logic tick_1024_reg,
   input logic run_state_reg,
   input logic [7:0] key_level_reg
);
   int gap_reg;
   int age_reg;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Zero until the first tick, so the divider phase after reset is free
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         gap_reg <= 0;
      else if (tick_1024_reg)
         gap_reg <= 1;
      else if (gap_reg != 0)
         gap_reg <= gap_reg + 1;
   end
   // Pin history is only valid three cycles after reset
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         age_reg <= 0;
      else if (age_reg < 3)
         age_reg <= age_reg + 1;
   end
   tick_pulse_a:
      assert property (tick_1024_reg |=> !tick_1024_reg) else $error("tick too wide");
   tick_period_a:
      assert property (tick_1024_reg && gap_reg != 0 |-> gap_reg == TICK_DIV)
         else $error("tick spacing wrong");
   ready_wait_a:
      assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("late answer");
   ready_pulse_a:
      assert property (pready |=> !pready) else $error("ready too wide");
   ready_cause_a:
      assert property (pready |-> psel && penable) else $error("ready without access");
   rdata_idle_a:
      assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
   err_map_a:
      assert property (pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'h0))
         else $error("error response wrong");
   key_port_a:
      assert property (age_reg == 3 |-> key_level_reg == $past(key_pins, 3))
         else $error("port level lag");
   run_tick_a:
      assert property ($changed(run_state_reg) |-> tick_1024_reg || $past(tick_1024_reg)
         || $past(tick_1024_reg, 2)) else $error("run change off tick");
endmodule
bind swkc_top swkc_props #(.TICK_DIV(TICK_DIV)) u_props (.pclk, .presetn, .psel, .penable,
   .paddr, .prdata, .pready, .pslverr, .key_pins, .tick_1024_reg, .run_state_reg,
   .key_level_reg);

// file: test/swkc_keys_model.sv
// Push keys on the port lines, active high, with contact bounce at release
`timescale 1ns/10ps
module swkc_keys_model
(
   input wire pclk,
   output logic [7:0] key_pins
);
   // No port interrupt listens on these lines here
   initial key_pins = 8'h00;
   task push(input logic [7:0] k);
      begin
         @(posedge pclk);
         key_pins <= key_pins | k;
      end
   endtask
   // Off gaps and on blips last 1.5 ticks: gaps stay inside the release
   // filter, and every blip is seen by at least one tick sample
   task free(input logic [7:0] k, input int n);
      begin
         repeat (n)
         begin
            @(posedge pclk);
            key_pins <= key_pins & ~k;
            repeat (12) @(posedge pclk);
            key_pins <= key_pins | k;
            repeat (11) @(posedge pclk);
         end
         @(posedge pclk);
         key_pins <= key_pins & ~k;
      end
   endtask
endmodule

// file: test/swkc_top_tb.sv
// Self-checking bench for the stopwatch key block
`timescale 1ns/10ps
`include "swkc_defines.vh"
module swkc_top_tb;
   localparam DIV = 8;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, key_pins, key_level_reg, b;
   logic [31:0] pwdata = 32'h0, prdata, q, m;
   logic pready, pslverr, err, tick_1024_reg, run_state_reg, exp_run;
   logic ten_hz_irq_reg, one_hz_irq_reg, run_key_irq_reg, lap_key_irq_reg;
   logic [3:0] millis_digit = 4'h0, centis_digit = 4'h0, decis_digit = 4'h0;
   logic centis_overflow = 1'b0, decis_overflow = 1'b0;
   logic [11:0] cap;
   logic [2:0] mk [7] = '{3'h2, 3'h3, 3'h4, 3'h4, 3'h5, 3'h6, 3'h7};
   int fails = 0, checked = 0, s, c;
   always #10 pclk = ~pclk;
   swkc_keys_model keys (.pclk, .key_pins);
   swkc_top #(.TICK_DIV(DIV), .DEB_TICKS(3)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .key_pins, .millis_digit, .centis_digit,
      .decis_digit, .centis_overflow, .decis_overflow, .tick_1024_reg, .run_state_reg,
      .key_level_reg, .ten_hz_irq_reg, .one_hz_irq_reg, .run_key_irq_reg, .lap_key_irq_reg);
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      begin
         checked++;
         if (seen !== exp)
         begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         // The wait ends when pready is seen high, or else at the watchdog
         do
            @(posedge pclk);
         while (pready !== 1'b1);
         q = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         chk(q, e);
      end
   endtask
   task ticks(input int n);
      repeat (n * DIV) @(posedge pclk);
   endtask
   // Release wait covers the filter window plus margin
   task press(input logic [7:0] k, input int n);
      begin
         keys.push(k);
         ticks(5);
         keys.free(k, n);
         ticks(6);
      end
   endtask
   task lap(input logic [7:0] k);
      begin
         cap = {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)};
         millis_digit <= cap[3:0];
         centis_digit <= cap[7:4];
         decis_digit <= cap[11:8];
         press(k, 0);
         millis_digit <= 4'h9 - cap[3:0];
         centis_digit <= 4'h9 - cap[7:4];
         decis_digit <= 4'h9 - cap[11:8];
      end
   endtask
   task rdcap(input logic [11:0] x);
      begin
         rd(`SWKC_OFS_MILLIS, {28'h0, x[3:0]});
         rd(`SWKC_OFS_CENTIS, {28'h0, x[7:4]});
         rd(`SWKC_OFS_DECIS, {28'h0, x[11:8]});
      end
   endtask
   task results;
      begin
         $display("checked %0d failed %0d", checked, fails);
         if (fails == 0 && checked > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial
   begin
      repeat (60000) @(posedge pclk);
      fails++;
      results;
   end
   initial
   begin
      void'($urandom(32'hCA7544B5));
      exp_run = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`SWKC_OFS_CTRL, 32'h0);
      rd(`SWKC_OFS_FLAGS, 32'h0);
      rd(`SWKC_OFS_MASK, 32'h0);
      rd(8'h20, 32'h0);
      chk(err, 1'b1);
      m = $urandom & 32'h1F;
      apb(1'b1, `SWKC_OFS_CTRL, m);
      rd(`SWKC_OFS_CTRL, m);
      apb(1'b1, `SWKC_OFS_CTRL, 32'h0);
      $display("test registers done");
      apb(1'b1, `SWKC_OFS_RUN, 32'h1);
      ticks(2);
      press(8'h01, 0);
      rd(`SWKC_OFS_RUN, 32'h1);
      rd(`SWKC_OFS_FLAGS, 32'h0);
      apb(1'b1, `SWKC_OFS_RUN, 32'h0);
      ticks(2);
      rd(`SWKC_OFS_RUN, 32'h0);
      $display("test software run done");
      for (s = 0; s < 2; s++)
      begin
         m = s[0] ? 32'hC : 32'h0;
         apb(1'b1, `SWKC_OFS_MASK, m);
         apb(1'b1, `SWKC_OFS_CTRL, s[0] ? 32'h3 : 32'h1);
         press(s[0] ? 8'h02 : 8'h01, 2);
         exp_run = ~exp_run;
         rd(`SWKC_OFS_RUN, {31'h0, exp_run});
         apb(1'b1, `SWKC_OFS_RUN, {31'h0, ~exp_run});
         ticks(2);
         rd(`SWKC_OFS_RUN, {31'h0, exp_run});
         chk(run_key_irq_reg, m[2]);
         lap(s[0] ? 8'h01 : 8'h02);
         rd(`SWKC_OFS_FLAGS, 32'hC);
         chk(lap_key_irq_reg, m[3]);
         rdcap(cap);
         apb(1'b1, `SWKC_OFS_FLAGS, 32'h0);
         rd(`SWKC_OFS_FLAGS, 32'hC);
         apb(1'b1, `SWKC_OFS_FLAGS, 32'hC);
         rd(`SWKC_OFS_FLAGS, 32'h0);
      end
      $display("test direct keys done");
      for (c = 1; c < 8; c++)
      begin
         b = 8'h01 << mk[c - 1];
         apb(1'b1, `SWKC_OFS_CTRL, {27'h0, c[2:0], 2'b01});
         keys.push(b);
         ticks(2);
         keys.push(8'h01);
         ticks(3);
         rd(`SWKC_OFS_KEYS, {24'h0, b | 8'h01});
         keys.free(b, 0);
         ticks(3);
         keys.free(8'h01, 0);
         ticks(6);
         press(b | 8'h01, 0);
         exp_run = ~exp_run;
         rd(`SWKC_OFS_RUN, {31'h0, exp_run});
      end
      // Seven accepted run presses leave the run key flag set
      rd(`SWKC_OFS_FLAGS, 32'h4);
      apb(1'b1, `SWKC_OFS_FLAGS, 32'h4);
      $display("test key mask done");
      apb(1'b1, `SWKC_OFS_MASK, 32'h2);
      centis_overflow <= 1'b1;
      decis_overflow <= 1'b1;
      @(posedge pclk);
      centis_overflow <= 1'b0;
      decis_overflow <= 1'b0;
      ticks(1);
      rd(`SWKC_OFS_FLAGS, 32'h3);
      chk({ten_hz_irq_reg, one_hz_irq_reg}, 2'b01);
      lap(8'h02);
      rd(`SWKC_OFS_FLAGS, 32'h2B);
      lap(8'h02);
      rdcap(cap);
      rd(`SWKC_OFS_FLAGS, 32'h3B);
      apb(1'b1, `SWKC_OFS_FLAGS, 32'hF);
      rd(`SWKC_OFS_FLAGS, 32'h30);
      rd(`SWKC_OFS_DECIS, {28'h0, cap[11:8]});
      rd(`SWKC_OFS_DECIS, {28'h0, 4'h9 - cap[11:8]});
      rd(`SWKC_OFS_MILLIS, {28'h0, 4'h9 - cap[3:0]});
      rd(`SWKC_OFS_FLAGS, 32'h0);
      rd(`SWKC_OFS_DECIS, {28'h0, 4'h9 - cap[11:8]});
      $display("test capture done");
      results;
   end
endmodule
